// File: inc/isc_pkg.sv
package isc_pkg;
  // ****************************************
  // register bus geometry and map
  // ****************************************
  localparam int             ADDR_W     = 4;
  localparam int             DATA_W     = 4;
  localparam logic [3:0]     REG_ENABLE = 4'h0; // interrupt_control_reg
  localparam logic [3:0]     REG_STATUS = 4'h1;
  localparam logic [3:0]     REG_POWER  = 4'h2;
  localparam logic [3:0]     RD_ZERO    = 4'h0;

  // ****************************************
  // sources, fields and vectors
  // ****************************************
  localparam int             NUM_SRC     = 3;
  localparam logic [1:0]     SRC_EXT     = 2'h0;
  localparam logic [1:0]     SRC_TMR     = 2'h1;
  localparam logic [1:0]     SRC_SIO     = 2'h2;
  localparam int             STAT_ACTIVE = 3;
  localparam int             PWR_STANDBY = 0;
  localparam int             PWR_SETTLE  = 1;
  localparam logic [7:0]     VEC_EXT     = 8'h10;
  localparam logic [7:0]     VEC_TMR     = 8'h20;
  localparam logic [7:0]     VEC_SIO     = 8'h30;
  localparam logic [7:0]     VEC_RST     = 8'h00;
  localparam logic [2:0]     EN_RST      = 3'h0;

  // ****************************************
  // oscillator settle count
  // ****************************************
  localparam int             SETTLE_CLOCKS = 8;
  localparam logic [2:0]     SETTLE_LAST   = 3'(SETTLE_CLOCKS - 1);
  localparam logic [2:0]     CNT_ZERO      = 3'h0;
  localparam logic [2:0]     CNT_ONE       = 3'h1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_RUN, ST_STANDBY, ST_SETTLE} isc_pwr_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } isc_sync_t;

  typedef struct packed {
    logic prev;
  } isc_edge_t;
endpackage : isc_pkg

// File: rtl/isc_edge_det.sv
`timescale 1ns/1ps
module isc_edge_det
  import isc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic level,
  output logic      rise
);
  isc_edge_t edge_reg;
  isc_edge_t edge_next;

  // ****************************************
  // low to high detect
  // ****************************************
  // prev starts low, so a pin already high at reset counts once
  always_comb begin
    edge_next      = edge_reg;
    edge_next.prev = level;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= edge_next;
    end
  end

  assign rise = level & ~edge_reg.prev;
endmodule : isc_edge_det

// File: rtl/isc_interrupt_standby.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module isc_interrupt_standby
  import isc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              extIrqPin,
  input  wire logic              restartPin,
  input  wire logic              restartPortInput,
  input  wire logic              timerOverflow,
  input  wire logic              timerStart,
  input  wire logic              serialDone,
  input  wire logic              haltOp,
  input  wire logic              returnFromInterruptOp,
  output logic                   irqAccept,
  output logic                   ctxRestore,
  output logic      [7:0]        vectorAddr,
  output logic                   irqActive,
  output logic                   cpuClkEn,
  output logic                   oscEnable,
  output logic                   standby
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    isc_pwr_t          state;
    logic [2:0]        cnt;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] req;
    logic              active;
    logic [1:0]        activeSrc;
    logic [7:0]        vector;
    logic              accept;
    logic              restore;
    logic              clkEn;
    logic              oscEn;
    logic              standby;
    logic [DATA_W-1:0] rdData;
  } isc_ctl_t;

  localparam isc_ctl_t CTL_RST = '{
    state: ST_RUN, cnt: CNT_ZERO, enable: EN_RST, req: EN_RST,
    active: 1'b0, activeSrc: SRC_EXT, vector: VEC_RST,
    accept: 1'b0, restore: 1'b0, clkEn: 1'b1, oscEn: 1'b1,
    standby: 1'b0, rdData: RD_ZERO};

  isc_ctl_t           ctl_reg;
  isc_ctl_t           ctl_next;
  logic               rstSyncN;
  logic               extRise;
  logic               restartRise;
  logic [NUM_SRC-1:0] evt;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] pend;
  logic [1:0]         pick;

  // ****************************************
  // helpers
  // ****************************************
  // fixed priority, lowest index wins
  function automatic logic [1:0] pickSrc(input logic [NUM_SRC-1:0] p);
    if (p[SRC_EXT]) begin
      return SRC_EXT;
    end else if (p[SRC_TMR]) begin
      return SRC_TMR;
    end
    return SRC_SIO;
  endfunction : pickSrc

  function automatic logic [7:0] vecOf(input logic [1:0] s);
    unique case (s)
      SRC_EXT: return VEC_EXT;
      SRC_TMR: return VEC_TMR;
      default: return VEC_SIO;
    endcase
  endfunction : vecOf

  // ****************************************
  // reset release and pin edges
  // ****************************************
  isc_rst_sync u_rst (
    .clk      (clk),
    .rst_n    (rst_n),
    .rstSyncN (rstSyncN)
  );

  isc_edge_det u_ext_edge (
    .clk   (clk),
    .rstN  (rstSyncN),
    .level (extIrqPin),
    .rise  (extRise)
  );

  isc_edge_det u_restart_edge (
    .clk   (clk),
    .rstN  (rstSyncN),
    .level (restartPin),
    .rise  (restartRise)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    ctl_next         = ctl_reg;
    ctl_next.accept  = 1'b0;
    ctl_next.restore = 1'b0;
    ctl_next.rdData  = RD_ZERO;
    evt              = {serialDone, timerOverflow, extRise};
    clr              = '0;
    pend             = ctl_reg.req & ctl_reg.enable;
    pick             = pickSrc(pend);

    // software enables, writable only in run, so they hold through standby and settle
    if (regWr && regAddr == REG_ENABLE && ctl_reg.state == ST_RUN) begin
      ctl_next.enable = regWdata[NUM_SRC-1:0];
    end

    // read data lands one cycle after the strobe
    if (regRd) begin
      unique case (regAddr)
        REG_ENABLE: ctl_next.rdData = {1'b0, ctl_reg.enable};
        REG_STATUS: begin
          ctl_next.rdData[NUM_SRC-1:0] = ctl_reg.req;
          ctl_next.rdData[STAT_ACTIVE] = ctl_reg.active;
        end
        REG_POWER: begin
          ctl_next.rdData[PWR_STANDBY] = ctl_reg.state == ST_STANDBY;
          ctl_next.rdData[PWR_SETTLE]  = ctl_reg.state == ST_SETTLE;
        end
        default: ctl_next.rdData = RD_ZERO;
      endcase
    end

    // return clears only the serviced source; start clears timer
    if (returnFromInterruptOp && ctl_reg.active) begin
      clr[ctl_reg.activeSrc] = 1'b1;
      ctl_next.active        = 1'b0;
      ctl_next.restore       = 1'b1;
    end
    if (timerStart) begin
      clr[SRC_TMR] = 1'b1;
    end

    // set beats clear; a disabled source never raises its flag
    ctl_next.req = (ctl_reg.req & ~clr) | (evt & ctl_reg.enable);

    // accept only when running and idle, flags wait meanwhile
    if (ctl_reg.state == ST_RUN && !ctl_reg.active && |pend && !haltOp) begin
      ctl_next.active    = 1'b1;
      ctl_next.activeSrc = pick;
      ctl_next.vector    = vecOf(pick);
      ctl_next.accept    = 1'b1;
    end

    // power sequencing
    unique case (ctl_reg.state)
      ST_RUN: begin
        if (haltOp) begin
          ctl_next.state   = ST_STANDBY;
          ctl_next.clkEn   = 1'b0;
          ctl_next.oscEn   = 1'b0;
          ctl_next.standby = 1'b1;
        end
      end
      ST_STANDBY: begin
        if (restartRise && restartPortInput) begin
          ctl_next.state = ST_SETTLE;
          ctl_next.oscEn = 1'b1;
          ctl_next.cnt   = CNT_ZERO;
        end
      end
      ST_SETTLE: begin
        // clk stands in for the restarted oscillator here
        if (ctl_reg.cnt == SETTLE_LAST) begin
          ctl_next.state   = ST_RUN;
          ctl_next.clkEn   = 1'b1;
          ctl_next.standby = 1'b0;
        end else begin
          ctl_next.cnt = ctl_reg.cnt + CNT_ONE;
        end
      end
    endcase
  end

  // reset in any state, standby included, returns everything to start
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctl_reg <= CTL_RST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ****************************************
  // outputs, all straight from flops
  // ****************************************
  assign regRdata   = ctl_reg.rdData;
  assign irqAccept  = ctl_reg.accept;
  assign ctxRestore = ctl_reg.restore;
  assign vectorAddr = ctl_reg.vector;
  assign irqActive  = ctl_reg.active;
  assign cpuClkEn   = ctl_reg.clkEn;
  assign oscEnable  = ctl_reg.oscEn;
  assign standby    = ctl_reg.standby;

  // ****************************************
  // assertions
  // ****************************************
  property p_prio;
    @(posedge clk) disable iff (!rstSyncN)
    (ctl_reg.accept && ctl_reg.vector != VEC_EXT)
      |-> !($past(ctl_reg.req[SRC_EXT]) && $past(ctl_reg.enable[SRC_EXT]));
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower source taken over pending external");

  property p_extSet;
    @(posedge clk) disable iff (!rstSyncN)
    (extRise && ctl_reg.enable[SRC_EXT]) |=> ctl_reg.req[SRC_EXT];
  endproperty
  a_extSet: assert property (p_extSet)
    else $error("external edge did not set request");

  property p_extClr;
    @(posedge clk) disable iff (!rstSyncN)
    (returnFromInterruptOp && ctl_reg.active && ctl_reg.activeSrc == SRC_EXT && !extRise)
      |=> !ctl_reg.req[SRC_EXT] && ctxRestore;
  endproperty
  a_extClr: assert property (p_extClr)
    else $error("return did not clear external request");

  property p_noAcceptAsleep;
    @(posedge clk) disable iff (!rstSyncN)
    (ctl_reg.state != ST_RUN) |=> !irqAccept;
  endproperty
  a_noAcceptAsleep: assert property (p_noAcceptAsleep)
    else $error("interrupt accepted while not running");

  property p_tmrStart;
    @(posedge clk) disable iff (!rstSyncN)
    (timerStart && !timerOverflow) |=> !ctl_reg.req[SRC_TMR];
  endproperty
  a_tmrStart: assert property (p_tmrStart)
    else $error("timer start left timer request set");

  property p_disabledQuiet;
    @(posedge clk) disable iff (!rstSyncN)
    (!ctl_reg.enable[SRC_SIO] && !ctl_reg.req[SRC_SIO]) |=> !ctl_reg.req[SRC_SIO];
  endproperty
  a_disabledQuiet: assert property (p_disabledQuiet)
    else $error("disabled serial source set its flag");

  property p_noNest;
    @(posedge clk) disable iff (!rstSyncN)
    irqAccept |-> !$past(irqActive) && irqActive;
  endproperty
  a_noNest: assert property (p_noNest)
    else $error("nested interrupt accepted");

  property p_enGate;
    @(posedge clk) disable iff (!rstSyncN)
    (irqAccept && vectorAddr == VEC_TMR) |-> $past(ctl_reg.enable[SRC_TMR]);
  endproperty
  a_enGate: assert property (p_enGate)
    else $error("disabled timer request started");

  property p_halt;
    @(posedge clk) disable iff (!rstSyncN)
    (haltOp && ctl_reg.state == ST_RUN) |=> standby && !cpuClkEn && !oscEnable;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not stop clocks");

  property p_wake;
    @(posedge clk) disable iff (!rstSyncN)
    (ctl_reg.state == ST_STANDBY && restartRise && restartPortInput)
      |=> (!cpuClkEn && oscEnable)[*8] ##1 cpuClkEn && !standby;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not take eight settle clocks");

  property p_wakeMask;
    @(posedge clk) disable iff (!rstSyncN)
    (ctl_reg.state == ST_STANDBY && !restartPortInput) |=> ctl_reg.state == ST_STANDBY;
  endproperty
  a_wakeMask: assert property (p_wakeMask)
    else $error("woke with restart port not input");

  c_ext: cover property (@(posedge clk) disable iff (!rstSyncN)
    irqAccept && vectorAddr == VEC_EXT);
  c_queued: cover property (@(posedge clk) disable iff (!rstSyncN)
    ctxRestore ##1 irqAccept);
  c_wake: cover property (@(posedge clk) disable iff (!rstSyncN)
    $rose(cpuClkEn));
endmodule : isc_interrupt_standby

// File: rtl/isc_rst_sync.sv
`timescale 1ns/1ps
module isc_rst_sync
  import isc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      rstSyncN
);
  isc_sync_t sync_reg;
  isc_sync_t sync_next;

  // ****************************************
  // release path
  // ****************************************
  // first stage only feeds the second, keeps metastability off the tree
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = 1'b1;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign rstSyncN = sync_reg.s2;
endmodule : isc_rst_sync

// File: tb/interrupt_and_standby_control_test.sv
`timescale 1ns/1ps
module interrupt_and_standby_control_test;
  import isc_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic              clk              = 1'b0;
  logic              rst_n            = 1'b0;
  logic [ADDR_W-1:0] regAddr          = '0;
  logic [DATA_W-1:0] regWdata         = '0;
  logic              regWr            = 1'b0;
  logic              regRd            = 1'b0;
  logic              extIrqPin        = 1'b0;
  logic              restartPin       = 1'b0;
  logic              restartPortInput = 1'b0;
  logic              timerOverflow    = 1'b0;
  logic              timerStart       = 1'b0;
  logic              serialDone       = 1'b0;
  logic              haltOp           = 1'b0;
  logic [3:0]        retDelay         = 4'h8;
  logic [DATA_W-1:0] regRdata;
  logic              returnFromInterruptOp;
  logic              irqAccept;
  logic              ctxRestore;
  logic              irqActive;
  logic              cpuClkEn;
  logic              oscEnable;
  logic              standby;
  logic [7:0]        vectorAddr;
  int                fails            = 0;
  int                n_tests          = 0;
  int                cyc              = 0;

  // free running: restart edge and settle count are both seen on clk, so no stop in standby
  always #4 clk = ~clk;

  isc_interrupt_standby uut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .extIrqPin, .restartPin, .restartPortInput, .timerOverflow, .timerStart, .serialDone,
    .haltOp, .returnFromInterruptOp, .irqAccept, .ctxRestore, .vectorAddr, .irqActive,
    .cpuClkEn, .oscEnable, .standby);

  isc_cpu_model cpu (.clk, .irqAccept, .retDelay, .returnFromInterruptOp);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out;
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [3:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk({4'h0, regRdata}, {4'h0, exp});
  endtask : rd

  // bit 0 external edge, bit 1 timer, bit 2 serial
  task automatic ev(input logic [2:0] m);
    @(posedge clk);
    extIrqPin     <= m[0];
    timerOverflow <= m[1];
    serialDone    <= m[2];
    @(posedge clk);
    extIrqPin     <= 1'b0;
    timerOverflow <= 1'b0;
    serialDone    <= 1'b0;
  endtask : ev

  // steps at least once so a stale accept is not counted twice
  task automatic wait_acc(input logic [7:0] v);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (irqAccept !== 1'b1 && i < 30);
    chk({7'h0, irqAccept}, 8'h01);
    chk(vectorAddr, v);
  endtask : wait_acc

  // return shows as a one-cycle restore pulse with the routine closed
  task automatic wait_ret;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (ctxRestore !== 1'b1 && i < 30);
    chk({6'h0, ctxRestore, irqActive}, 8'h02);
  endtask : wait_ret

  task automatic no_acc(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (irqAccept === 1'b1) k++;
    end
    chk(k[7:0], 8'h00);
  endtask : no_acc

  task automatic halt;
    @(posedge clk);
    haltOp <= 1'b1;
    @(posedge clk);
    haltOp <= 1'b0;
    #1;
  endtask : halt

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({4'h0, standby, cpuClkEn, oscEnable, irqActive}, 8'h06);
    chk(vectorAddr, VEC_RST);
    rd(REG_ENABLE, 4'h0);
    rd(REG_STATUS, 4'h0);
  endtask : do_reset

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    wr(REG_ENABLE, 4'hF);
    rd(REG_ENABLE, 4'h7);
    wr(REG_STATUS, 4'hF);
    rd(REG_STATUS, 4'h0);
    rd(4'hF, 4'h0);
    wr(REG_ENABLE, 4'h0);
  endtask : t_regs

  task automatic t_gate;
    ev(3'h7);
    rd(REG_STATUS, 4'h0);
    no_acc(8);
  endtask : t_gate

  // all three fire together: served one by one in rank order
  task automatic t_prio;
    wr(REG_ENABLE, 4'h7);
    ev(3'h7);
    wait_acc(VEC_EXT);
    rd(REG_STATUS, 4'hF);
    wait_acc(VEC_TMR);
    wait_acc(VEC_SIO);
    wait_ret();
    rd(REG_STATUS, 4'h0);
  endtask : t_prio

  task automatic t_mask;
    ev(3'h1);
    wait_acc(VEC_EXT);
    ev(3'h2);
    wr(REG_ENABLE, 4'h0);
    no_acc(20);
    rd(REG_STATUS, 4'h2);
    @(posedge clk);
    timerStart <= 1'b1;
    @(posedge clk);
    timerStart <= 1'b0;
    rd(REG_STATUS, 4'h0);
    wr(REG_ENABLE, 4'h4);
    ev(3'h4);
    wait_acc(VEC_SIO);
    wait_ret();
  endtask : t_mask

  // settle window counted as cycles with oscillator on and clock gated
  task automatic t_standby;
    int n;
    wr(REG_ENABLE, 4'h1);
    halt();
    chk({5'h0, standby, cpuClkEn, oscEnable}, 8'h04);
    wr(REG_ENABLE, 4'h7);
    rd(REG_ENABLE, 4'h1);
    rd(REG_POWER, 4'h1);
    chk(vectorAddr, VEC_SIO);
    ev(3'h1);
    @(posedge clk);
    restartPin <= 1'b1;
    no_acc(12);
    chk({7'h0, standby}, 8'h01);
    @(posedge clk);
    restartPin       <= 1'b0;
    restartPortInput <= 1'b1;
    @(posedge clk);
    restartPin <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (cpuClkEn === 1'b1) break;
      if (oscEnable === 1'b1) n++;
    end
    chk(n[7:0], 8'h08);
    chk({7'h0, standby}, 8'h00);
    wait_acc(VEC_EXT);
    @(posedge clk);
    restartPin <= 1'b0;
    wait_ret();
  endtask : t_standby

  task automatic t_rst;
    halt();
    chk({7'h0, standby}, 8'h01);
    do_reset();
  endtask : t_rst

  // ****************************************
  // run control
  // ****************************************
  // ceiling sits well above the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    do_reset();
    t_regs();
    t_gate();
    t_prio();
    t_mask();
    t_standby();
    t_rst();
    close_out();
  end
endmodule : interrupt_and_standby_control_test

// File: tb/isc_cpu_model.sv
`timescale 1ns/1ps
module isc_cpu_model (
  input  wire logic       clk,
  input  wire logic       irqAccept,
  input  wire logic [3:0] retDelay,
  output logic            returnFromInterruptOp
);
  logic retPulse = 1'b0;

  // ****************************************
  // routine body: return after retDelay cycles
  // ****************************************
  // one return per accept, since routines never nest
  always @(posedge clk) begin
    if (irqAccept === 1'b1) begin
      repeat (retDelay) @(posedge clk);
      retPulse <= 1'b1;
      @(posedge clk);
      retPulse <= 1'b0;
    end
  end

  assign returnFromInterruptOp = retPulse;
endmodule : isc_cpu_model
